// ### sidr_master_model.sv
// Purpose: behavioural spi master facing the identifier-read slave
// Assumes: mode 0, sck period 125 ns, sck stands low between frames
// Notes:   so sampled on sck rise; an undriven so reads as z
`timescale 1ns/1ns
module sidr_master_model (
    // serial pins out
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    // serial pins in
    input  wire logic so_o,
    input  wire logic so_oe_n
);
    initial begin
        sck    = 1'b0;
        cs_n   = 1'b1;
        si     = 1'b0;
        hold_n = 1'b1;
    end
    // long low phase leaves the slave time to launch its bit
    task automatic tick(input logic b, output logic s);
        si = b;
        #70;
        sck = 1'b1;
        s = so_oe_n ? 1'bz : so_o;
        #55;
        sck = 1'b0;
    endtask : tick
    task automatic xfer(input logic [31:0] v, input int n, output logic [31:0] c);
        logic s;
        c = '0;
        for (int i = n - 1; i >= 0; i--) begin
            tick(v[i], s);
            c = {c[30:0], s};
        end
    endtask : xfer
    task automatic sel(input logic v);
        #70;
        cs_n = v;
        #70;
    endtask : sel
    // hold only with sck low; toggles and si noise meanwhile
    task automatic pause(input logic desel);
        logic s;
        #60;
        hold_n = 1'b0;
        #20;
        cs_n = desel;
        repeat (3) tick(~si, s);
    endtask : pause
    task automatic resume();
        cs_n = 1'b0;
        #30;
        hold_n = 1'b1;
        #40;
    endtask : resume
endmodule : sidr_master_model

// ### sidr_pkg.sv
// Purpose: constants for the identifier-read serial slave
// Assumes: spi mode 0 or 3, msb first, byte wide opcodes
// Notes:   opcodes are fixed localparams; maker and product codes are slave parameters of plain defaults
package sidr_pkg;
    localparam int        ID_W         = 32;
    localparam int        MFR_LSB      = 21;
    localparam int        PROD_LSB     = 7;
    localparam int        CAP_LSB      = 3;
    localparam int        REV_LSB      = 0;
    localparam int        MFR_W        = 11;
    localparam int        PROD_W       = 14;
    localparam int        CAP_W        = 4;
    localparam int        REV_W        = 3;
    localparam logic [7:0] IDENT_READ_CMD      = 8'h9f;
    localparam logic [7:0] IDENT_READ_FAST_CMD = 8'h99;
    localparam logic [3:0] CAP_256KB   = 4'h2;
    localparam logic [2:0] REV_INITIAL = 3'h0;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [4:0] ID_BIT_TOP  = 5'h1f;
    localparam logic [4:0] ID_BIT_LAST = 5'h00;
    typedef enum logic [2:0] {
        SIDR_ST_OPCODE = 3'b000,
        SIDR_ST_DUMMY  = 3'b001,
        SIDR_ST_SEND   = 3'b010,
        SIDR_ST_DONE   = 3'b011
    } sidr_state_t;
endpackage : sidr_pkg

// ### sidr_slave.sv
// Purpose: serial slave answering the two identifier-read instructions, with hold
// Assumes: sck, cs_n, si, hold_n asynchronous, sampled by core_clk
// Notes:   so is two signals; so_oe_n low while driving
//
// Behaviour
// - identifier is 32 bits: maker 31..21, product 20..7, capacity 6..3, revision 2..0.
// - four-bit capacity field encodes the 256 Kb size.
// - three-bit revision field starts from a fixed initial code.
// - normal read opcode after select; four identifier bytes follow without dummy cycles.
// - fast read sends opcode then one dummy byte before identifier bytes.
// - hold freezes the transaction state without resetting it.
// - master releases hold with sck low; sck toggles ignored while held.
// - while held, si ignored and so is high impedance.
// - paused state survives deselection; resumes when selected with hold high.
`timescale 1ns/1ns
module sidr_slave
    import sidr_pkg::*;
#(
    parameter logic [10:0] MFR_CODE  = 11'h000, // arbitrary value
    parameter logic [13:0] PROD_CODE = 14'h0000 // arbitrary value
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // serial pins
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic hold_n,
    output logic      so_o,
    output logic      so_oe_n,
    // status
    output logic      busy
);
    logic sck_s, cs_n_s, si_s, hold_n_s;

    sidr_sync u_sync_sck  (.core_clk(core_clk), .arst_n(arst_n), .async_in(sck),
                           .sync_out(sck_s));
    sidr_sync u_sync_cs   (.core_clk(core_clk), .arst_n(arst_n), .async_in(cs_n),
                           .sync_out(cs_n_s));
    sidr_sync u_sync_si   (.core_clk(core_clk), .arst_n(arst_n), .async_in(si),
                           .sync_out(si_s));
    sidr_sync u_sync_hold (.core_clk(core_clk), .arst_n(arst_n), .async_in(hold_n),
                           .sync_out(hold_n_s));

    logic [ID_W-1:0] ident;
    assign ident[MFR_LSB +: MFR_W]   = MFR_CODE;
    assign ident[PROD_LSB +: PROD_W] = PROD_CODE;
    assign ident[CAP_LSB +: CAP_W]   = CAP_256KB;
    assign ident[REV_LSB +: REV_W]   = REV_INITIAL;

    sidr_state_t st_q, st_d;
    logic [2:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d;
    logic [4:0]  idx_q, idx_d;
    logic        sck_prev_q, sck_prev_d;
    logic        paused_q, paused_d;
    logic        so_q, so_d;
    logic        oe_n_q, oe_n_d;
    logic        act_q, act_d;
    logic        rise, fall, run;

    // pause entered on sync hold low with sck low once busy; cs rise does not clear a pause
    assign rise = sck_s & ~sck_prev_q;
    assign fall = ~sck_s & sck_prev_q;
    assign run  = ~cs_n_s & ~paused_q;

    always_comb begin
        st_d       = st_q;
        bit_d      = bit_q;
        sh_d       = sh_q;
        idx_d      = idx_q;
        so_d       = so_q;
        oe_n_d     = oe_n_q;
        act_d      = act_q;
        paused_d   = paused_q;
        sck_prev_d = sck_s;
        if (!hold_n_s && !sck_s && act_q) begin
            paused_d = 1'b1;
        end else if (hold_n_s && !sck_s && !cs_n_s) begin
            paused_d = 1'b0;
        end
        if (paused_d) begin
            oe_n_d = 1'b1;
        end else if (paused_q) begin
            // resume: the held bit must be back before the next rise samples it
            if (st_q == SIDR_ST_SEND) begin
                so_d   = ident[idx_q];
                oe_n_d = 1'b0;
            end
        end else if (cs_n_s) begin
            st_d   = SIDR_ST_OPCODE;
            bit_d  = 3'h0;
            idx_d  = ID_BIT_TOP;
            oe_n_d = 1'b1;
            act_d  = 1'b0;
        end else if (run) begin
            // sck edges only count while running, so held toggles are lost
            if (rise) begin
                act_d = 1'b1;
                unique case (st_q)
                    SIDR_ST_OPCODE: begin
                        sh_d  = {sh_q[6:0], si_s};
                        bit_d = bit_q + 3'h1;
                        if (bit_q == BIT_LAST) begin
                            if ({sh_q[6:0], si_s} == IDENT_READ_CMD) begin
                                st_d = SIDR_ST_SEND;
                            end else if ({sh_q[6:0], si_s} == IDENT_READ_FAST_CMD) begin
                                st_d = SIDR_ST_DUMMY;
                            end else begin
                                st_d = SIDR_ST_DONE;
                            end
                        end
                    end
                    SIDR_ST_DUMMY: begin
                        bit_d = bit_q + 3'h1;
                        if (bit_q == BIT_LAST) begin
                            st_d = SIDR_ST_SEND;
                        end
                    end
                    SIDR_ST_SEND: begin
                        if (idx_q == ID_BIT_LAST) begin
                            st_d = SIDR_ST_DONE;
                        end else begin
                            idx_d = idx_q - 5'h01;
                        end
                    end
                    SIDR_ST_DONE: begin
                        st_d = SIDR_ST_DONE;
                    end
                    default: st_d = SIDR_ST_DONE;
                endcase
            end
            if (fall) begin
                if (st_q == SIDR_ST_SEND) begin
                    so_d   = ident[idx_q];
                    oe_n_d = 1'b0;
                end else begin
                    oe_n_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= SIDR_ST_OPCODE;
            bit_q      <= 3'h0;
            sh_q       <= 8'h00;
            idx_q      <= ID_BIT_TOP;
            so_q       <= 1'b0;
            oe_n_q     <= 1'b1;
            act_q      <= 1'b0;
            paused_q   <= 1'b0;
            // same as the synchroniser preload, so reset leaves no false edge
            sck_prev_q <= 1'b1;
        end else begin
            st_q       <= st_d;
            bit_q      <= bit_d;
            sh_q       <= sh_d;
            idx_q      <= idx_d;
            so_q       <= so_d;
            oe_n_q     <= oe_n_d;
            act_q      <= act_d;
            paused_q   <= paused_d;
            sck_prev_q <= sck_prev_d;
        end
    end

    assign so_o    = so_q;
    assign so_oe_n = oe_n_q;
    assign busy    = act_q;

    property p_hold_hiz;
        @(posedge core_clk) disable iff (!arst_n)
        paused_q |-> so_oe_n;
    endproperty
    a_hold_hiz: assert property (p_hold_hiz) else $error("so driven while paused");

    property p_freeze;
        @(posedge core_clk) disable iff (!arst_n)
        (paused_q && paused_d) |=> ($stable(idx_q) && $stable(st_q) && $stable(bit_q));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while paused");

    property p_redrive;
        @(posedge core_clk) disable iff (!arst_n)
        (paused_q && !paused_d && st_q == SIDR_ST_SEND)
            |=> (!so_oe_n && so_o == ident[$past(idx_q)]);
    endproperty
    a_redrive: assert property (p_redrive) else $error("held bit not restored");

    property p_msb;
        @(posedge core_clk) disable iff (!arst_n)
        (run && fall && st_q == SIDR_ST_SEND && !paused_d) |=> (so_o == ident[$past(idx_q)]);
    endproperty
    a_msb: assert property (p_msb) else $error("wrong identifier bit");

    property p_norm;
        @(posedge core_clk) disable iff (!arst_n)
        (run && rise && st_q == SIDR_ST_OPCODE && bit_q == BIT_LAST
         && {sh_q[6:0], si_s} == IDENT_READ_CMD && !paused_d) |=> st_q == SIDR_ST_SEND;
    endproperty
    a_norm: assert property (p_norm) else $error("normal read not entered");

    property p_fast;
        @(posedge core_clk) disable iff (!arst_n)
        (run && rise && st_q == SIDR_ST_OPCODE && bit_q == BIT_LAST
         && {sh_q[6:0], si_s} == IDENT_READ_FAST_CMD && !paused_d) |=> st_q == SIDR_ST_DUMMY;
    endproperty
    a_fast: assert property (p_fast) else $error("fast read not entered");

    // bit 0 still stands in the done state until the next fall, so only
    // opcode and dummy phases must be silent
    property p_dummy;
        @(posedge core_clk) disable iff (!arst_n)
        (st_q == SIDR_ST_OPCODE || st_q == SIDR_ST_DUMMY) |-> so_oe_n;
    endproperty
    a_dummy: assert property (p_dummy) else $error("driven before identifier");

    property p_keep;
        @(posedge core_clk) disable iff (!arst_n)
        (paused_q && cs_n_s) |=> $stable(st_q);
    endproperty
    a_keep: assert property (p_keep) else $error("pause lost on deselect");

    property p_ids;
        @(posedge core_clk) disable iff (!arst_n)
        ident[CAP_LSB +: CAP_W] == CAP_256KB && ident[REV_LSB +: REV_W] == REV_INITIAL;
    endproperty
    a_ids: assert property (p_ids) else $error("bad capacity or revision");

    c_send: cover property (@(posedge core_clk) st_q == SIDR_ST_SEND);
    c_dummy: cover property (@(posedge core_clk) st_q == SIDR_ST_DUMMY);
    c_pause: cover property (@(posedge core_clk) paused_q && cs_n_s);
    c_resume: cover property (@(posedge core_clk) paused_q && !paused_d && st_q == SIDR_ST_SEND);
endmodule : sidr_slave

// ### sidr_sync.sv
// Purpose: three flop synchroniser with agreement filter
// Assumes: input asynchronous to core_clk
// Notes:   first flop feeds only the second
`timescale 1ns/1ns
module sidr_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // signal
    input  wire logic async_in,
    output logic      sync_out
);
    logic s1_q, s2_q, s3_q, out_q;
    logic out_d;

    always_comb begin
        out_d = out_q;
        if (s2_q == s3_q) begin
            out_d = s3_q;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            s3_q  <= 1'b1;
            out_q <= 1'b1;
        end else begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    // all stages preload high: cs_n and hold_n idle high, sck as in mode 3
    assign sync_out = out_q;
endmodule : sidr_sync

// ### tb_spi_device_id_read_and_hold.sv
// Purpose: self-checking bench for the identifier-read slave
// Assumes: slave puts the held bit back on so as soon as hold is released
// Notes:   si toggles every bit while the slave talks
`timescale 1ns/1ns
module tb_spi_device_id_read_and_hold;
    import sidr_pkg::*;
    localparam logic [10:0] MFR   = 11'h5a3;   // arbitrary value
    localparam logic [13:0] PROD  = 14'h2c71;  // arbitrary value
    localparam logic [31:0] ID    = {MFR, PROD, CAP_256KB, REV_INITIAL};
    localparam logic [31:0] NOISE = 32'h5555_5555;
    logic        core_clk, arst_n, sck, cs_n, si, hold_n, so_o, so_oe_n, busy;
    logic [31:0] c;
    logic [11:0] hi;
    int          fails, checked;
    sidr_slave #(.MFR_CODE(MFR), .PROD_CODE(PROD)) DUT (.core_clk(core_clk),
        .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
        .so_o(so_o), .so_oe_n(so_oe_n), .busy(busy));
    sidr_master_model mst (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
        .so_o(so_o), .so_oe_n(so_oe_n));
    always #5 core_clk = ~core_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic sc_normal();
        mst.sel(1'b0);
        mst.xfer({24'h0, IDENT_READ_CMD}, 8, c);
        check(c[7:0], 8'hzz);
        check(busy, 1'b1);
        mst.xfer(NOISE, 32, c);
        check(c, ID);
        mst.xfer(NOISE, 1, c);
        check(c[0], 1'bz);
        mst.sel(1'b1);
    endtask : sc_normal
    task automatic sc_fast();
        mst.sel(1'b0);
        mst.xfer({24'h0, IDENT_READ_FAST_CMD}, 8, c);
        check(c[7:0], 8'hzz);
        // dummy carries the normal opcode to prove its value is ignored
        mst.xfer({24'h0, IDENT_READ_CMD}, 8, c);
        check(c[7:0], 8'hzz);
        mst.xfer(NOISE, 32, c);
        check(c, ID);
        mst.sel(1'b1);
    endtask : sc_fast
    task automatic sc_bad();
        mst.sel(1'b0);
        mst.xfer(32'h03, 8, c);
        mst.xfer(NOISE, 32, c);
        check(c, 32'hzzzz_zzzz);
        mst.sel(1'b1);
    endtask : sc_bad
    task automatic sc_hold_cmd();
        mst.sel(1'b0);
        mst.xfer({28'h0, IDENT_READ_CMD[7:4]}, 4, c);
        mst.pause(1'b1);
        check(so_oe_n, 1'b1);
        mst.resume();
        mst.xfer({28'h0, IDENT_READ_CMD[3:0]}, 4, c);
        mst.xfer(NOISE, 32, c);
        check(c, ID);
        mst.sel(1'b1);
    endtask : sc_hold_cmd
    task automatic sc_hold_send();
        mst.sel(1'b0);
        mst.xfer({24'h0, IDENT_READ_CMD}, 8, c);
        mst.xfer(NOISE, 12, c);
        hi = c[11:0];
        mst.pause(1'b0);
        check(so_oe_n, 1'b1);
        mst.resume();
        mst.xfer(NOISE, 20, c);
        check({hi, c[19:0]}, ID);
        mst.sel(1'b1);
    endtask : sc_hold_send
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    initial begin
        core_clk = 1'b0;
        arst_n   = 1'b0;
        fails    = 0;
        checked  = 0;
        repeat (4) @(negedge core_clk);
        arst_n = 1'b1;
        check(busy, 1'b0);
        repeat (8) @(negedge core_clk);
        // pin delays are all multiples of 5 ns: this offset keeps every pin edge off core_clk edges
        #2;
        sc_normal();
        sc_fast();
        sc_bad();
        sc_hold_cmd();
        sc_hold_send();
        print_verdict();
    end
endmodule : tb_spi_device_id_read_and_hold
